//--- include/acc_pkg.sv
// Package with register map, field positions and reset values of the comparator control block.
package acc_pkg;
	localparam int NUM_CMP = 3;
	localparam logic [11:0] OFS_CTRL_A3 = 12'hEC8;
	localparam logic [11:0] OFS_CTRL_B3 = 12'hEC9;
	localparam logic [11:0] OFS_CTRL_A2 = 12'hECC;
	localparam logic [11:0] OFS_CTRL_B2 = 12'hECD;
	localparam logic [11:0] OFS_CTRL_A1 = 12'hED0;
	localparam logic [11:0] OFS_CTRL_B1 = 12'hED1;
	localparam logic [11:0] OFS_MIRROR = 12'hED4;
	localparam logic [11:0] OFS_FLAGS = 12'hED8;
	localparam logic [11:0] OFS_PIN = 12'hEDC;
	localparam int BIT_EN = 7;
	localparam int BIT_OUT = 6;
	localparam int BIT_POL = 4;
	localparam int BIT_HYS = 1;
	localparam int BIT_SYNC = 0;
	localparam int BIT_RISE = 1;
	localparam int BIT_FALL = 0;
	localparam int PIN_SEL_LSB = 0;
	localparam int PIN_DIR_LSB = 4;
	localparam logic [7:0] CTRL_A_WMASK = 8'h93;
	localparam logic [7:0] CTRL_B_WMASK = 8'h03;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_PIN = 8'h70;
	localparam int INSTR_DIV = 4;
endpackage

//--- hw/acc_top.sv
// Control and result logic for three analog comparators behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Three comparator instances, each with own control, status and output logic.
// [RQ2] Raw result is low when non-inverting input is below inverting input.
// [RQ3] First control register holds enable, result, polarity, hysteresis, sync bits.
// [RQ4] Second control register holds rising and falling edge interrupt enables.
// [RQ5] Enable bit powers comparator; clear puts it in lowest power state.
// [RQ6] Result readable from own status bit or shared mirror register.
// [RQ7] Software selects pin source and clears pin direction to drive result.
// [RQ8] Internal result relatched each instruction cycle; pin result not latched.
// [RQ9] Polarity bit set inverts result; clear passes it straight.
// [RQ10] Status bit follows table: zero when inverting higher, swapped by polarity.
// [RQ11] Hysteresis bit enables input offset on that comparator.
// [RQ12] Enabled edge on result sets the comparator interrupt flag.
// [RQ13] Software clears flag; an edge during the clear keeps it set.
// [RQ14] Sync mode latches result on falling edge of timer prescaled clock.
// [RQ15] Toggling polarity or enable can still raise the interrupt when disabled.
// [RQ16] Edge detectors watch the latched polarity adjusted result.
module acc_top (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  cmp_raw_in,
	input  wire logic        timer_clk_in,
	output logic      [2:0]  unit_power_select,
	output logic      [2:0]  hysteresis_select,
	output logic      [2:0]  cmp_irq_flag,
	output logic             pin_out,
	output logic             pin_oe
);
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_a_reg [3];
	logic [7:0] ctrl_b_reg [3];
	logic [2:0] flag_reg;
	logic [7:0] pin_reg;
	logic [2:0] raw_s1_reg;
	logic [2:0] raw_s2_reg;
	logic       tmr_s1_reg;
	logic       tmr_s2_reg;
	logic       tmr_d_reg;
	logic [1:0] div_reg;
	logic [2:0] res_reg;
	logic [2:0] res_d_reg;
	logic [2:0] pin_res_reg;
	logic [31:0] rdata_next;
	logic [2:0] live;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [2:0] edge_hit;
	logic [2:0] clr_req;
	logic [2:0] sel_a;
	logic [2:0] sel_b;
	wire        wr_en = psel & penable & pwrite;
	// Read data is captured in the setup cycle, so it stands at the edge that sees pready.
	wire        setup = psel & ~penable;
	wire        rd_setup = setup & ~pwrite;
	wire        instr_tick = (div_reg == 2'(acc_pkg::INSTR_DIV - 1));
	wire        tmr_fall = tmr_d_reg & ~tmr_s2_reg;
	wire        sel_mirror = (paddr == acc_pkg::OFS_MIRROR);
	wire        sel_flags = (paddr == acc_pkg::OFS_FLAGS);
	wire        sel_pin = (paddr == acc_pkg::OFS_PIN);
	wire        mapped = (|sel_a) | (|sel_b) | sel_mirror | sel_flags | sel_pin;
	wire [1:0]  pin_src = pin_reg[acc_pkg::PIN_SEL_LSB +: 2];
	wire [2:0]  pin_dir = pin_reg[acc_pkg::PIN_DIR_LSB +: 3];
	assign sel_a[0] = (paddr == acc_pkg::OFS_CTRL_A1);
	assign sel_a[1] = (paddr == acc_pkg::OFS_CTRL_A2);
	assign sel_a[2] = (paddr == acc_pkg::OFS_CTRL_A3);
	assign sel_b[0] = (paddr == acc_pkg::OFS_CTRL_B1);
	assign sel_b[1] = (paddr == acc_pkg::OFS_CTRL_B2);
	assign sel_b[2] = (paddr == acc_pkg::OFS_CTRL_B3);
	assign clr_req = (wr_en && sel_flags) ? pwdata[2:0] : 3'h0;
	////////////////////////////////////////////////////////////////////////////////
	// Analog inputs are asynchronous to the core clock, so they are synchronised first.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			raw_s1_reg <= 3'h0;
			raw_s2_reg <= 3'h0;
			tmr_s1_reg <= 1'b0;
			tmr_s2_reg <= 1'b0;
			tmr_d_reg  <= 1'b0;
			div_reg    <= 2'h0;
		end else begin
			raw_s1_reg <= cmp_raw_in;
			raw_s2_reg <= raw_s1_reg;
			tmr_s1_reg <= timer_clk_in;
			tmr_s2_reg <= tmr_s1_reg;
			tmr_d_reg  <= tmr_s2_reg;
			div_reg    <= instr_tick ? 2'h0 : div_reg + 2'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < acc_pkg::NUM_CMP; g++) begin : g_cmp // RQ1
			wire en  = ctrl_a_reg[g][acc_pkg::BIT_EN];
			wire pol = ctrl_a_reg[g][acc_pkg::BIT_POL];
			wire syn = ctrl_a_reg[g][acc_pkg::BIT_SYNC];
			// A disabled comparator presents a low raw level; polarity still applies.
			assign live[g] = (en & raw_s2_reg[g]) ^ pol; // RQ2 RQ5 RQ9 RQ10 RQ15
			wire take = syn ? tmr_fall : instr_tick; // RQ8 RQ14
			assign rise[g] = res_reg[g] & ~res_d_reg[g]; // RQ16
			assign fall[g] = ~res_reg[g] & res_d_reg[g]; // RQ16
			assign edge_hit[g] = (rise[g] & ctrl_b_reg[g][acc_pkg::BIT_RISE]) |
				(fall[g] & ctrl_b_reg[g][acc_pkg::BIT_FALL]); // RQ12
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					ctrl_a_reg[g] <= acc_pkg::RST_CTRL;
					ctrl_b_reg[g] <= acc_pkg::RST_CTRL;
					res_reg[g]    <= 1'b0;
					res_d_reg[g]  <= 1'b0;
					flag_reg[g]   <= 1'b0;
				end else begin
					if (wr_en && sel_a[g]) begin
						ctrl_a_reg[g] <= pwdata[7:0] & acc_pkg::CTRL_A_WMASK; // RQ3
					end
					if (wr_en && sel_b[g]) begin
						ctrl_b_reg[g] <= pwdata[7:0] & acc_pkg::CTRL_B_WMASK; // RQ4
					end
					if (take) begin
						res_reg[g] <= live[g];
					end
					res_d_reg[g] <= res_reg[g];
					// Set wins over a simultaneous clear.
					flag_reg[g] <= edge_hit[g] | (flag_reg[g] & ~clr_req[g]); // RQ13
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		rdata_next = 32'h0;
		for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
			if (sel_a[i]) begin
				rdata_next[7:0] = ctrl_a_reg[i];
				rdata_next[acc_pkg::BIT_OUT] = res_reg[i]; // RQ6 RQ10
			end
			if (sel_b[i]) begin
				rdata_next[7:0] = ctrl_b_reg[i];
			end
		end
		if (sel_mirror) begin
			rdata_next[2:0] = res_reg; // RQ6
		end
		if (sel_flags) begin
			rdata_next[2:0] = flag_reg;
		end
		if (sel_pin) begin
			rdata_next[7:0] = pin_reg;
		end
	end
	// The pin path bypasses the instruction latch to keep its delay short.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_reg           <= acc_pkg::RST_PIN;
			prdata            <= 32'h0;
			pready            <= 1'b0;
			pslverr           <= 1'b0;
			pin_res_reg       <= 3'h0;
			pin_out           <= 1'b0;
			pin_oe            <= 1'b0;
			unit_power_select <= 3'h0;
			hysteresis_select <= 3'h0;
			cmp_irq_flag      <= 3'h0;
		end else begin
			if (wr_en && sel_pin) begin
				pin_reg <= pwdata[7:0] & 8'h73;
			end
			prdata  <= rd_setup ? rdata_next : 32'h0;
			pready  <= setup;
			pslverr <= setup & ~mapped;
			pin_res_reg <= live; // RQ8
			pin_out <= (pin_src == 2'h0) ? 1'b0 : pin_res_reg[pin_src - 2'h1]; // RQ7
			pin_oe  <= (pin_src != 2'h0) & ~pin_dir[pin_src - 2'h1]; // RQ7
			for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
				unit_power_select[i] <= ctrl_a_reg[i][acc_pkg::BIT_EN]; // RQ5
				hysteresis_select[i] <= ctrl_a_reg[i][acc_pkg::BIT_HYS]; // RQ11
			end
			cmp_irq_flag <= flag_reg;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
		edge_hit[0] |=> flag_reg[0]) else $error("edge did not set flag"); // RQ12
	a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
		(edge_hit[1] && clr_req[1]) |=> flag_reg[1]) else $error("clear beat set"); // RQ13
	a_clear_works: assert property (@(posedge clk_sys) disable iff (rst)
		(clr_req[2] && !edge_hit[2]) |=> !flag_reg[2]) else $error("flag not cleared"); // RQ13
	a_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(!instr_tick && !ctrl_a_reg[0][acc_pkg::BIT_SYNC]) |=> $stable(res_reg[0]))
		else $error("result changed off tick"); // RQ8
	a_tick_period: assert property (@(posedge clk_sys) disable iff (rst)
		instr_tick |=> !instr_tick [*3] ##1 instr_tick) else $error("tick period wrong"); // RQ8
	a_pol_invert: assert property (@(posedge clk_sys) disable iff (rst)
		(!ctrl_a_reg[1][acc_pkg::BIT_EN]) |-> (live[1] == ctrl_a_reg[1][acc_pkg::BIT_POL]))
		else $error("disabled result wrong"); // RQ9
	a_power_out: assert property (@(posedge clk_sys) disable iff (rst)
		##1 unit_power_select[2] == $past(ctrl_a_reg[2][acc_pkg::BIT_EN]))
		else $error("power select mismatch"); // RQ5
	a_hys_out: assert property (@(posedge clk_sys) disable iff (rst)
		##1 hysteresis_select[0] == $past(ctrl_a_reg[0][acc_pkg::BIT_HYS]))
		else $error("hysteresis mismatch"); // RQ11
	a_rise_edge: assert property (@(posedge clk_sys) disable iff (rst)
		rise[0] |-> $past(res_reg[0]) == 1'b0) else $error("rise without edge"); // RQ16
	////////////////////////////////////////////////////////////////////////////////
	// Bus timing: zero wait states, answer and error stand in the access cycle.
	a_pready_setup: assert property ( // RQ6
		@(posedge clk_sys) disable iff (rst)
		setup |=> pready)
		else $error("pready missing in access");

	a_pready_idle: assert property ( // RQ6
		@(posedge clk_sys) disable iff (rst)
		!setup |=> !pready)
		else $error("pready outside access");

	a_slverr_unmap: assert property ( // RQ6
		@(posedge clk_sys) disable iff (rst)
		(setup && !mapped) |=> pslverr)
		else $error("unmapped access without error");

	a_slverr_ok: assert property ( // RQ6
		@(posedge clk_sys) disable iff (rst)
		(setup && mapped) |=> !pslverr)
		else $error("mapped access with error");

	a_rdata_idle: assert property ( // RQ6
		@(posedge clk_sys) disable iff (rst)
		!rd_setup |=> (prdata == 32'h0))
		else $error("read data outside read");

	a_mirror_read: assert property ( // RQ6
		@(posedge clk_sys) disable iff (rst)
		(rd_setup && sel_mirror) |=> (prdata[2:0] == $past(res_reg)))
		else $error("mirror read wrong");

	// Register writes and masks.
	a_write_ctrl_a: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		(wr_en && sel_a[1]) |=> (ctrl_a_reg[1] == ($past(pwdata[7:0]) & acc_pkg::CTRL_A_WMASK)))
		else $error("control a write lost");

	a_write_ctrl_b: assert property ( // RQ4
		@(posedge clk_sys) disable iff (rst)
		(wr_en && sel_b[0]) |=> (ctrl_b_reg[0] == ($past(pwdata[7:0]) & acc_pkg::CTRL_B_WMASK)))
		else $error("control b write lost");

	a_ctrl_a_mask: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		(ctrl_a_reg[0] & ~acc_pkg::CTRL_A_WMASK) == 8'h00)
		else $error("reserved control a bit set");

	a_ctrl_b_mask: assert property ( // RQ4
		@(posedge clk_sys) disable iff (rst)
		(ctrl_b_reg[2] & ~acc_pkg::CTRL_B_WMASK) == 8'h00)
		else $error("reserved control b bit set");

	a_unmapped_keep: assert property ( // RQ7
		@(posedge clk_sys) disable iff (rst)
		(wr_en && !mapped) |=> $stable(pin_reg))
		else $error("unmapped write changed pin setup");

	// Result path.
	a_live_enabled: assert property ( // RQ2 RQ10
		@(posedge clk_sys) disable iff (rst)
		ctrl_a_reg[0][acc_pkg::BIT_EN] |->
			(live[0] == (raw_s2_reg[0] ^ ctrl_a_reg[0][acc_pkg::BIT_POL])))
		else $error("enabled result wrong");

	a_disabled_pol: assert property ( // RQ5
		@(posedge clk_sys) disable iff (rst)
		!ctrl_a_reg[2][acc_pkg::BIT_EN] |-> (live[2] == ctrl_a_reg[2][acc_pkg::BIT_POL]))
		else $error("disabled result not polarity");

	a_tick_take: assert property ( // RQ8
		@(posedge clk_sys) disable iff (rst)
		(instr_tick && !ctrl_a_reg[1][acc_pkg::BIT_SYNC]) |=> (res_reg[1] == $past(live[1])))
		else $error("result not latched on tick");

	a_sync_take: assert property ( // RQ14
		@(posedge clk_sys) disable iff (rst)
		(tmr_fall && ctrl_a_reg[2][acc_pkg::BIT_SYNC]) |=> (res_reg[2] == $past(live[2])))
		else $error("result not latched on timer fall");

	a_sync_hold: assert property ( // RQ14
		@(posedge clk_sys) disable iff (rst)
		(!tmr_fall && ctrl_a_reg[2][acc_pkg::BIT_SYNC]) |=> $stable(res_reg[2]))
		else $error("synced result moved off timer fall");

	a_pin_unlatched: assert property ( // RQ8
		@(posedge clk_sys) disable iff (rst)
		##1 pin_res_reg == $past(live))
		else $error("pin result latched");

	a_pin_off: assert property ( // RQ7
		@(posedge clk_sys) disable iff (rst)
		(pin_src == 2'h0) |=> (!pin_oe && !pin_out))
		else $error("pin driven with no source");

	a_fall_edge: assert property ( // RQ16
		@(posedge clk_sys) disable iff (rst)
		fall[1] |-> ($past(res_reg[1]) == 1'b1))
		else $error("fall without edge");

	// Flags and copies.
	a_no_spurious: assert property ( // RQ12
		@(posedge clk_sys) disable iff (rst)
		(!edge_hit[0] && !flag_reg[0]) |=> !flag_reg[0])
		else $error("flag set without edge");

	a_flag_out: assert property ( // RQ12
		@(posedge clk_sys) disable iff (rst)
		##1 cmp_irq_flag == $past(flag_reg))
		else $error("flag output mismatch");

	a_power_copy: assert property ( // RQ5
		@(posedge clk_sys) disable iff (rst)
		##1 unit_power_select[0] == $past(ctrl_a_reg[0][acc_pkg::BIT_EN]))
		else $error("power select copy mismatch");

	a_hys_copy: assert property ( // RQ11
		@(posedge clk_sys) disable iff (rst)
		##1 hysteresis_select[2] == $past(ctrl_a_reg[2][acc_pkg::BIT_HYS]))
		else $error("hysteresis copy mismatch");

	c_rise_irq: cover property (@(posedge clk_sys) rise[0] && edge_hit[0]);
	c_fall_irq: cover property (@(posedge clk_sys) fall[1] && edge_hit[1]);
	c_set_clear: cover property (@(posedge clk_sys) edge_hit[1] && clr_req[1]);
	c_sync_take: cover property (@(posedge clk_sys) tmr_fall && ctrl_a_reg[2][acc_pkg::BIT_SYNC]);
endmodule
`default_nettype wire

//--- tb/acc_top_tb.sv
// Self-checking testbench for the comparator control block.
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb;
	logic        clk_sys;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  cmp_raw_in;
	logic        timer_clk_in;
	logic [2:0]  unit_power_select;
	logic [2:0]  hysteresis_select;
	logic [2:0]  cmp_irq_flag;
	logic        pin_out;
	logic        pin_oe;
	logic [31:0] rd;
	logic        er;
	int          fails;
	int          comparisons;
	acc_top u_acc_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_raw_in(cmp_raw_in), .timer_clk_in(timer_clk_in),
		.unit_power_select(unit_power_select), .hysteresis_select(hysteresis_select),
		.cmp_irq_flag(cmp_irq_flag), .pin_out(pin_out), .pin_oe(pin_oe));
	always #2.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	// Read data and error are taken at the edge that samples pready high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt();
		repeat (16) @(posedge clk_sys);
	endtask
	task automatic end_sim();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, timer_clk_in} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		cmp_raw_in = 3'h0;
		fails = 0;
		comparisons = 0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		apb(0, acc_pkg::OFS_CTRL_A1, 8'h00);
		chk(rd, 32'h00000000);
		apb(0, acc_pkg::OFS_PIN, 8'h00);
		chk(rd, {24'h000000, acc_pkg::RST_PIN});
		$display("test reset done");
		cmp_raw_in <= 3'h1;
		apb(1, acc_pkg::OFS_CTRL_A1, 8'hEE);
		wt();
		apb(0, acc_pkg::OFS_CTRL_A1, 8'h00);
		chk(rd, 32'h000000C2);
		chk({unit_power_select, hysteresis_select}, 6'h09);
		apb(0, acc_pkg::OFS_MIRROR, 8'h00);
		chk(rd, 32'h00000001);
		apb(1, acc_pkg::OFS_CTRL_A1, 8'h92);
		wt();
		apb(0, acc_pkg::OFS_CTRL_A1, 8'h00);
		chk(rd, 32'h00000092);
		$display("test polarity done");
		apb(1, acc_pkg::OFS_CTRL_B1, 8'h02);
		apb(1, acc_pkg::OFS_FLAGS, 8'h07);
		cmp_raw_in <= 3'h0;
		wt();
		chk(cmp_irq_flag, 3'h1);
		apb(1, acc_pkg::OFS_FLAGS, 8'h01);
		wt();
		chk(cmp_irq_flag, 3'h0);
		apb(1, acc_pkg::OFS_CTRL_B1, 8'h01);
		cmp_raw_in <= 3'h1;
		wt();
		chk(cmp_irq_flag, 3'h1);
		apb(1, acc_pkg::OFS_FLAGS, 8'h01);
		apb(1, acc_pkg::OFS_CTRL_B2, 8'h02);
		apb(1, acc_pkg::OFS_CTRL_A2, 8'h10);
		wt();
		chk(cmp_irq_flag, 3'h2);
		$display("test interrupt done");
		apb(1, acc_pkg::OFS_CTRL_A3, 8'h81);
		cmp_raw_in <= 3'h5;
		wt();
		apb(0, acc_pkg::OFS_MIRROR, 8'h00);
		chk(rd, 32'h00000002);
		timer_clk_in <= 1'b1;
		wt();
		timer_clk_in <= 1'b0;
		wt();
		apb(0, acc_pkg::OFS_MIRROR, 8'h00);
		chk(rd, 32'h00000006);
		$display("test sync done");
		apb(1, acc_pkg::OFS_CTRL_A1, 8'h82);
		apb(1, acc_pkg::OFS_PIN, 8'h61);
		wt();
		chk({pin_oe, pin_out}, 2'h3);
		cmp_raw_in <= 3'h4;
		wt();
		chk({pin_oe, pin_out}, 2'h2);
		apb(0, 12'h000, 8'h00);
		chk({rd, 31'h00000000, er}, 64'h1);
		$display("test pin and unmapped done");
		end_sim();
	end
	initial begin
		repeat (6000) @(posedge clk_sys);
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
